// ===== verilog/bar_bank_defines.vh
// Contract
// RL1: CSR I/O window, 256 bytes, base bits 31:8
// RL2: CSR window bit0 reads 1, 7:1 zero
// RL3: Window 1 size/type from setup at 0xAC
// RL4: Setup bit 31 clear disables window
// RL5: Window 1: memory 4KB-2GB, I/O 64B-256B
// RL6: Window 1 forwards via translated base 0xA8
// RL7: Base bits writable only where setup bit set
// RL8: Window 1 type 00=32-bit, 01=64-bit
// RL9: Window 2 32-bit only, type reads 00
// RL10: Window 2 size/type from setup 0x00C
// RL11: Window 2 memory 4KB to 2GB
// RL12: Window 2 translated via base 0x008
// RL13: Bit 3 zero, 11:4 zero, bit0 memory
`ifndef BAR_BANK_DEFINES_VH
`define BAR_BANK_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CSR_IO_BASE   8'h14
`define OFS_WIN1_BASE     8'h18
`define OFS_WIN2_BASE     8'h1C
`define OFS_WIN1_SETUP    8'hAC
`define OFS_WIN1_XLAT     8'hA8
`define CSR_OFS_WIN2_SETUP 12'h00C
`define CSR_OFS_WIN2_XLAT  12'h008

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SETUP_ENABLE_BIT  31
`define SETUP_IO_BIT      0
`define SETUP_TYPE64_BIT  1
`define CSR_IO_BASE_LSB   8
`define WIN_BASE_LSB      12
`define CSR_IO_BASE_RST   24'h000000
`define WIN_BASE_RST      20'h00000
`define TYPE_32BIT        2'h0
`define TYPE_64BIT        2'h1

// ----------------------------------------
// Window size limits
// ----------------------------------------
`define IO_WIN_MIN_LSB    6
`define IO_WIN_FIXED_MASK 32'hFFFFFF00
`define MEM_WIN_MIN_MASK  32'hFFFFF000
`define WIN_TOP_MASK      32'h80000000

`endif

// ===== verilog/bridge_primary_bar_bank.v
// Our own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "bar_bank_defines.vh"

module bridge_primary_bar_bank
#(
  parameter IO_MIN_LSB = `IO_WIN_MIN_LSB
)
(
  // Clock, reset, enable
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        clk_en,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Setup registers, loaded elsewhere
  input  wire [31:0] win1_setup,
  input  wire [31:0] win2_setup,
  // Translated bases
  input  wire [31:0] win1_xlat_base,
  input  wire [31:0] win2_xlat_base,
  // Address decode
  input  wire [31:0] txn_addr,
  input  wire        txn_io,
  input  wire        txn_valid,
  output reg         csr_hit,
  output reg         win1_hit,
  output reg         win2_hit,
  output reg  [31:0] fwd_addr
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  localparam NUM_WIN = 2;
  localparam WIN1    = 0;
  localparam WIN2    = 1;

  localparam [1:0] SEL_NONE = 2'h0;
  localparam [1:0] SEL_CSR  = 2'h1;
  localparam [1:0] SEL_WIN1 = 2'h2;
  localparam [1:0] SEL_WIN2 = 2'h3;

  // An I/O window may shrink to 64 bytes, so setup bits 7:6 also take part.
  localparam [31:0] IO_KEEP  = ~((32'h00000001 << IO_MIN_LSB) - 32'h00000001);
  localparam [31:0] MEM_KEEP = `MEM_WIN_MIN_MASK;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg  [23:0]        csr_base_reg;
  reg  [23:0]        csr_base_next;
  reg  [19:0]        win_base_reg  [0:NUM_WIN-1];
  wire [19:0]        win_base_next [0:NUM_WIN-1];
  reg  [31:0]        reg_rdata_next;
  reg                csr_hit_next;
  reg                win1_hit_next;
  reg                win2_hit_next;
  reg  [31:0]        fwd_addr_next;
  integer            wi;

  // ----------------------------------------
  // Per-window views
  // ----------------------------------------
  wire [31:0]        win_setup     [0:NUM_WIN-1];
  wire [31:0]        win_xlat      [0:NUM_WIN-1];
  wire [31:0]        win_mask      [0:NUM_WIN-1];
  wire [31:0]        win_fwd       [0:NUM_WIN-1];
  wire [NUM_WIN-1:0] win_io;
  wire [NUM_WIN-1:0] win_hit_raw;
  wire               csr_m;
  wire [1:0]         win1_type;
  wire [31:0]        csr_val;
  wire [31:0]        win1_val;
  wire [31:0]        win2_val;

  assign win_setup[WIN1] = win1_setup;                                          // [RL3]
  assign win_setup[WIN2] = win2_setup;                                          // [RL10]
  assign win_xlat[WIN1]  = win1_xlat_base;                                      // [RL6]
  assign win_xlat[WIN2]  = win2_xlat_base;                                      // [RL12]

  // Only window 1 may claim I/O space; window 2 stays memory whatever its setup holds.
  assign win_io[WIN1]    = win1_setup[`SETUP_IO_BIT];
  assign win_io[WIN2]    = 1'b0;                                                // [RL11]

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function [1:0] reg_sel;
    input [7:0] addr;
    begin
      case (addr)
        `OFS_CSR_IO_BASE: reg_sel = SEL_CSR;
        `OFS_WIN1_BASE:   reg_sel = SEL_WIN1;
        `OFS_WIN2_BASE:   reg_sel = SEL_WIN2;
        default:          reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  function [19:0] masked_write;
    input [19:0] old_v;
    input [19:0] new_v;
    input [19:0] mask;
    begin
      masked_write = (new_v & mask) | (old_v & ~mask);                          // [RL7]
    end
  endfunction

  // Bit 31 always compares, which caps every window at 2 GB.
  function [31:0] window_mask;
    input [31:0] setup;
    input        io;
    begin
      if (io)
        window_mask = `IO_WIN_FIXED_MASK | (setup & IO_KEEP);                   // [RL5]
      else
        window_mask = `WIN_TOP_MASK | (setup & MEM_KEEP);                       // [RL5] [RL11]
    end
  endfunction

  function [1:0] type_code;
    input [31:0] setup;
    input        io;
    begin
      if (!io && setup[`SETUP_TYPE64_BIT])
        type_code = `TYPE_64BIT;
      else
        type_code = `TYPE_32BIT;                                                // [RL8]
    end
  endfunction

  function window_match;
    input [31:0] addr;
    input [31:0] base;
    input [31:0] mask;
    input [31:0] setup;
    input        addr_io;
    input        space_io;
    begin
      window_match = setup[`SETUP_ENABLE_BIT] && (addr_io == space_io) &&
                     (((addr ^ base) & mask) == 32'h00000000);                  // [RL4]
    end
  endfunction

  // ----------------------------------------
  // Window slices
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi = gi + 1)
    begin : g_win
      wire [1:0]  my_sel;
      wire [31:0] base;

      assign my_sel       = (gi == WIN1) ? SEL_WIN1 : SEL_WIN2;
      assign base         = {win_base_reg[gi], 12'h000};
      assign win_mask[gi] = window_mask(win_setup[gi], win_io[gi]);

      assign win_base_next[gi] = (reg_wr && (reg_sel(reg_addr) == my_sel)) ?
                                 masked_write(win_base_reg[gi], reg_wdata[31:12], win_setup[gi][31:12]) :
                                 win_base_reg[gi];                              // [RL7]

      assign win_hit_raw[gi] = window_match(txn_addr, base, win_mask[gi], win_setup[gi],
                                            txn_io, win_io[gi]);                // [RL4]

      assign win_fwd[gi] = (win_xlat[gi] & win_mask[gi]) | (txn_addr & ~win_mask[gi]); // [RL6] [RL12]
    end
  endgenerate

  // ----------------------------------------
  // Read value composition
  // ----------------------------------------
  assign win1_type = type_code(win1_setup, win_io[WIN1]);                       // [RL8]
  assign csr_val   = {csr_base_reg, 7'h00, 1'b1};                               // [RL1] [RL2]
  assign win1_val  = {win_base_reg[WIN1], 8'h00, 1'b0, win1_type, win_io[WIN1]}; // [RL13]
  assign win2_val  = {win_base_reg[WIN2], 8'h00, 1'b0, `TYPE_32BIT, 1'b0};      // [RL9] [RL13]
  assign csr_m     = txn_io && (txn_addr[31:`CSR_IO_BASE_LSB] == csr_base_reg); // [RL1]

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  always @*
  begin
    csr_base_next = csr_base_reg;
    if (reg_wr && (reg_sel(reg_addr) == SEL_CSR))
      csr_base_next = reg_wdata[31:`CSR_IO_BASE_LSB];                           // [RL1]
  end

  // A read in the same cycle as a write returns the old value.
  always @*
  begin
    reg_rdata_next = 32'h00000000;
    if (reg_rd)
    begin
      case (reg_sel(reg_addr))
        SEL_CSR:  reg_rdata_next = csr_val;
        SEL_WIN1: reg_rdata_next = win1_val;
        SEL_WIN2: reg_rdata_next = win2_val;
        default:  reg_rdata_next = 32'h00000000;
      endcase
    end
  end

  // The control window wins over window 1, which wins over window 2.
  always @*
  begin
    csr_hit_next  = txn_valid && csr_m;
    win1_hit_next = txn_valid && !csr_m && win_hit_raw[WIN1];
    win2_hit_next = txn_valid && !csr_m && !win_hit_raw[WIN1] && win_hit_raw[WIN2];
  end

  always @*
  begin
    fwd_addr_next = 32'h00000000;
    if (win1_hit_next)
      fwd_addr_next = win_fwd[WIN1];                                            // [RL6]
    else if (win2_hit_next)
      fwd_addr_next = win_fwd[WIN2];                                            // [RL12]
  end

  // ----------------------------------------
  // Base registers
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      csr_base_reg <= `CSR_IO_BASE_RST;                                         // [RL2]
      for (wi = 0; wi < NUM_WIN; wi = wi + 1)
        win_base_reg[wi] <= `WIN_BASE_RST;                                      // [RL7]
    end
    else if (clk_en)
    begin
      csr_base_reg <= csr_base_next;
      for (wi = 0; wi < NUM_WIN; wi = wi + 1)
        win_base_reg[wi] <= win_base_next[wi];
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata <= 32'h00000000;
    else if (clk_en)
      reg_rdata <= reg_rdata_next;
  end

  // ----------------------------------------
  // Hit flags and forwarded address
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      csr_hit  <= 1'b0;
      win1_hit <= 1'b0;
      win2_hit <= 1'b0;
    end
    else if (clk_en)
    begin
      csr_hit  <= csr_hit_next;
      win1_hit <= win1_hit_next;
      win2_hit <= win2_hit_next;
    end
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
      fwd_addr <= 32'h00000000;
    else if (clk_en)
      fwd_addr <= fwd_addr_next;
  end

endmodule
`default_nettype wire

// ===== dv/bar_bank_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module bar_bank_checker
(
  // Watched ports
  input wire        sys_clk,
  input wire        rst_n,
  input wire [7:0]  reg_addr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire [31:0] win1_setup,
  input wire [31:0] win2_setup,
  input wire        txn_io,
  input wire        txn_valid,
  input wire        csr_hit,
  input wire        win1_hit,
  input wire        win2_hit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(a); $past(reg_rd) && $past(reg_addr) == a; endsequence
  property p_csr_lo; s_rd(8'h14) |-> reg_rdata[7:0] == 8'h01; endproperty
  a_csr_lo: assert property (p_csr_lo) else $error("csr low bits");
  property p_w1_lo; s_rd(8'h18) |-> reg_rdata[11:3] == 9'h000; endproperty
  a_w1_lo: assert property (p_w1_lo) else $error("win1 low bits");
  property p_w2_lo; s_rd(8'h1C) |-> reg_rdata[11:0] == 12'h000; endproperty
  a_w2_lo: assert property (p_w2_lo) else $error("win2 low bits");
  property p_w1_type;
    s_rd(8'h18) |-> reg_rdata[2:1] == {1'b0, $past(win1_setup[1] & ~win1_setup[0])};
  endproperty
  a_w1_type: assert property (p_w1_type) else $error("win1 type");
  property p_w2_dis; !$past(win2_setup[31]) |-> !win2_hit; endproperty
  a_w2_dis: assert property (p_w2_dis) else $error("win2 off hit");
  property p_hit_valid; !$past(txn_valid) |-> !(csr_hit || win1_hit || win2_hit); endproperty
  a_hit_valid: assert property (p_hit_valid) else $error("idle hit");
  property p_csr_io; csr_hit |-> $past(txn_io); endproperty
  a_csr_io: assert property (p_csr_io) else $error("csr hit on memory");
  property p_w2_mem; win2_hit |-> !$past(txn_io); endproperty
  a_w2_mem: assert property (p_w2_mem) else $error("win2 hit on io");
endmodule
bind bridge_primary_bar_bank bar_bank_checker u_chk (.sys_clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata,
  .win1_setup, .win2_setup, .txn_io, .txn_valid, .csr_hit, .win1_hit, .win2_hit);
`default_nettype wire

// ===== dv/bridge_primary_bar_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
module bridge_primary_bar_bank_tb;
  logic        sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, txn_io = 0, txn_valid = 0, ce = 1;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, x1 = 0, x2 = 0, txn_addr = 0, v, d1, d2;
  logic [31:0] win1_setup = 32'hFFFF0002, win2_setup = 32'hFFF00000;
  wire  [31:0] reg_rdata, fwd_addr;
  wire         csr_hit, win1_hit, win2_hit;
  int          error_cnt = 0, total_checks = 0;
  always #5 sys_clk = ~sys_clk;
  bridge_primary_bar_bank dut (.sys_clk, .rst_n, .clk_en(ce), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .win1_setup, .win2_setup, .win1_xlat_base(x1), .win2_xlat_base(x2), .txn_addr, .txn_io,
    .txn_valid, .csr_hit, .win1_hit, .win2_hit, .fwd_addr);
  function logic [31:0] bar(input logic [31:0] d, m, lo);
    return d & m | lo;
  endfunction
  task chk(input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 0;
    reg_rd <= 0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    acc(0, a, 0);
    chk(v & m, e);
  endtask
  task txn(input logic [31:0] a, input logic io);
    @(posedge sys_clk);
    txn_addr <= a;
    txn_io <= io;
    txn_valid <= 1;
    @(posedge sys_clk);
    txn_valid <= 0;
    @(negedge sys_clk);
  endtask
  task stop_test;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // The span is far beyond the roughly 130 cycles the sequence needs.
  initial
  begin
    #100000;
    error_cnt++;
    stop_test;
  end
  initial
  begin
    void'($urandom(62224));
    repeat (16) @(posedge sys_clk);
    rst_n <= 1;
    rd(8'h14, 32'h1);
    rd(8'h18, 32'h2);
    rd(8'h1C, 32'h0);
    repeat (4)
    begin
      d1 = $urandom & 32'h7FFFFFFF;
      d2 = $urandom | 32'h80000000;
      acc(1, 8'h18, d1);
      acc(1, 8'h1C, d2);
      acc(1, 8'h14, d2);
      acc(1, 8'h20, d1);
      rd(8'h18, bar(d1, 32'hFFFF0000, 2));
      rd(8'h1C, bar(d2, 32'hFFF00000, 0));
      rd(8'h14, bar(d2, 32'hFFFFFF00, 1));
      rd(8'h20, 32'h0);
      @(posedge sys_clk);
      ce <= 0;
      acc(1, 8'h1C, 32'h0);
      @(posedge sys_clk);
      ce <= 1;
      rd(8'h1C, bar(d2, 32'hFFF00000, 0));
    end
    @(posedge sys_clk);
    x1 <= $urandom;
    x2 <= $urandom;
    txn(bar(d2, 32'hFFF00000, 32'h1234), 0);
    chk(fwd_addr, bar(x2, 32'hFFF00000, 32'h1234));
    chk(win2_hit, 1);
    txn(bar(d1, 32'hFFFF0000, 32'h0ABC), 0);
    chk(fwd_addr, bar(x1, 32'hFFFF0000, 32'h0ABC));
    chk(win1_hit, 1);
    txn(bar(d2, 32'hFFFFFF00, 32'h10), 1);
    chk(csr_hit, 1);
    @(posedge sys_clk);
    win2_setup <= 32'h7FF00000;
    win1_setup <= 32'hFFFFFFC3;
    txn(bar(d2, 32'hFFF00000, 32'h1234), 0);
    chk(win2_hit, 0);
    txn(bar(d1, 32'hFFFF0000, 32'h3C), 1);
    chk(win1_hit, 1);
    chk(fwd_addr, bar(x1, 32'hFFFFFFC0, 32'h3C));
    txn(bar(d1, 32'hFFFF0000, 32'h7C), 1);
    chk(win1_hit, 0);
    rd(8'h18, 32'h1, 32'hFFF);
    stop_test;
  end
endmodule
`default_nettype wire
